// ### rtl/pfh_host.sv
// Host controller that drives command sequences and reads on a parallel flash
`timescale 1ns/1ps
module pfh_host #(
  parameter longint ERASE_TIMEOUT = pfh_pkg::ERASE_CYC // Poll timeout in cycles
) (
  input wire logic sys_clk, // System clock, 40 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic cmd_valid, // Request strobe, level until taken
  input wire logic [2:0] cmd_op, // Requested operation
  input wire logic [17:0] cmd_addr, // Byte or sector address
  input wire logic [7:0] cmd_wdata, // Byte to program
  input wire logic [7:0] data_lines_in, // Data lines as seen on the pins
  output logic cmd_ready, // Idle, request may be taken
  output logic rsp_valid, // Operation finished, one pulse
  output logic [7:0] rsp_rdata, // Read byte
  output logic rsp_timeout, // Completion polling timed out
  output logic [17:0] address_lines, // Address pins
  output logic [7:0] data_lines_out, // Data lines driven value
  output logic data_lines_oe, // Data lines drive enable, high drives
  output logic chip_sel_n, // Chip select pin
  output logic out_en_n, // Output enable pin
  output logic wr_strobe_n, // Write strobe pin
  output logic flash_reset_n // Device reset pin
);
  // Refuse a timeout of fewer than two cycles; one poll read already counts nine
  if (ERASE_TIMEOUT < 2) begin : g_bad_timeout
    $error("ERASE_TIMEOUT too small");
  end

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic [7:0] din_meta;
  logic [7:0] din_sync;
  always_ff @(posedge sys_clk) begin
    din_meta <= data_lines_in;
    din_sync <= din_meta;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {PFH_IDLE, PFH_ISSUE, PFH_WAIT, PFH_POLL, PFH_POLLW,
    PFH_END} pfh_state_t;
  pfh_state_t state;
  logic [2:0] op;
  logic [17:0] op_addr;
  logic [7:0] op_data;
  logic [2:0] step;
  logic [2:0] last_step;
  logic bc_start;
  logic bc_write;
  logic [17:0] bc_addr;
  logic [7:0] bc_wdata;
  logic bc_busy;
  logic bc_done;
  logic [7:0] bc_rdata;
  logic have_prev;
  logic [7:0] prev_read;
  logic [63:0] wait_cnt;

  // Step table of the unlock prefix shared by every write command
  always_comb begin
    bc_write = (op != pfh_pkg::OP_READ);
    bc_addr = op_addr;
    bc_wdata = op_data;
    last_step = (op == pfh_pkg::OP_PROGRAM) ? 3'h3 : 3'h5;
    if (op == pfh_pkg::OP_READ) begin
      bc_addr = op_addr;
    end else if (step == 3'h0 || step == 3'h3) begin
      bc_addr = pfh_pkg::ADDR_UNLOCK1;
      bc_wdata = pfh_pkg::DATA_UNLOCK1;
    end else if (step == 3'h1 || step == 3'h4) begin
      bc_addr = pfh_pkg::ADDR_UNLOCK2;
      bc_wdata = pfh_pkg::DATA_UNLOCK2;
    end else if (step == 3'h2) begin
      bc_addr = pfh_pkg::ADDR_UNLOCK1;
      bc_wdata = (op == pfh_pkg::OP_PROGRAM) ? pfh_pkg::CODE_PROGRAM : pfh_pkg::DATA_SETUP;
    end
    if (op != pfh_pkg::OP_READ && step == last_step) begin
      case (op)
        // Program only clears bits; the requester erases the block first
        pfh_pkg::OP_PROGRAM: begin
          bc_addr = op_addr;
          bc_wdata = op_data;
        end
        pfh_pkg::OP_CHIP_ERASE: begin
          bc_addr = pfh_pkg::ADDR_UNLOCK1;
          bc_wdata = pfh_pkg::CODE_CHIP;
        end
        pfh_pkg::OP_SECTOR_ERASE: begin
          bc_addr = op_addr;
          bc_wdata = pfh_pkg::CODE_SECTOR;
        end
        default: begin
          bc_addr = pfh_pkg::ADDR_UNLOCK1;
          bc_wdata = pfh_pkg::CODE_LOCK;
        end
      endcase
    end
    if (state == PFH_POLL || state == PFH_POLLW) begin
      bc_write = 1'b0;
      bc_addr = op_addr;
    end
  end

  always_ff @(posedge sys_clk) begin
    bc_start <= 1'b0;
    rsp_valid <= 1'b0;
    if (rst) begin
      // An operation cut by reset is dropped; the requester must reissue it
      state <= PFH_IDLE;
      op <= pfh_pkg::OP_READ;
      op_addr <= 18'h00000;
      op_data <= 8'h00;
      step <= 3'h0;
      cmd_ready <= 1'b0;
      rsp_rdata <= 8'h00;
      rsp_timeout <= 1'b0;
      have_prev <= 1'b0;
      prev_read <= 8'h00;
      wait_cnt <= 64'h0;
    end else begin
      case (state)
        PFH_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            op <= cmd_op;
            op_addr <= cmd_addr;
            op_data <= cmd_wdata;
            step <= 3'h0;
            rsp_timeout <= 1'b0;
            bc_start <= 1'b1;
            state <= PFH_WAIT;
          end
        end
        PFH_ISSUE: begin
          bc_start <= 1'b1;
          state <= PFH_WAIT;
        end
        PFH_WAIT: begin
          if (bc_done) begin
            if (op == pfh_pkg::OP_READ) begin
              rsp_rdata <= bc_rdata;
              state <= PFH_END;
            end else if (step == last_step) begin
              have_prev <= 1'b0;
              wait_cnt <= 64'h0;
              state <= PFH_POLL;
            end else begin
              step <= step + 3'h1;
              state <= PFH_ISSUE;
            end
          end
        end
        PFH_POLL: begin
          // Completion is two reads in a row with bit six equal; a program also needs bit seven to match the written byte
          bc_start <= 1'b1;
          state <= PFH_POLLW;
        end
        PFH_POLLW: begin
          wait_cnt <= wait_cnt + 64'h1;
          if (bc_done) begin
            have_prev <= 1'b1;
            prev_read <= bc_rdata;
            if (have_prev && prev_read[pfh_pkg::TOGGLE_BIT] == bc_rdata[pfh_pkg::TOGGLE_BIT]
                && (op != pfh_pkg::OP_PROGRAM
                || bc_rdata[pfh_pkg::POLL_BIT] == op_data[pfh_pkg::POLL_BIT])) begin
              rsp_rdata <= bc_rdata;
              state <= PFH_END;
            end else if (wait_cnt >= 64'(ERASE_TIMEOUT)) begin
              rsp_timeout <= 1'b1;
              rsp_rdata <= bc_rdata;
              state <= PFH_END;
            end else begin
              state <= PFH_POLL;
            end
          end
        end
        PFH_END: begin
          rsp_valid <= 1'b1;
          state <= PFH_IDLE;
        end
        default: begin
          state <= PFH_IDLE;
        end
      endcase
    end
  end

  // Device reset follows host reset; released so the device resumes in read mode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flash_reset_n <= 1'b0;
    end else begin
      flash_reset_n <= 1'b1;
    end
  end

  pfh_bus_cycle u_cycle (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(bc_start),
    .is_write(bc_write),
    .addr(bc_addr),
    .wdata(bc_wdata),
    .pin_data_in(din_sync),
    .busy(bc_busy),
    .done(bc_done),
    .rdata(bc_rdata),
    .address_lines(address_lines),
    .data_out(data_lines_out),
    .data_oe(data_lines_oe),
    .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n),
    .wr_strobe_n(wr_strobe_n)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence unlock_pair;
    bc_start && bc_addr == pfh_pkg::ADDR_UNLOCK1 && bc_wdata == pfh_pkg::DATA_UNLOCK1;
  endsequence
  first_unlock_a: assert property (@(posedge sys_clk) disable iff (rst)
    (bc_start && state == PFH_WAIT && op != pfh_pkg::OP_READ && step == 3'h0)
    |-> unlock_pair)
    else $error("command does not open with unlock cycle");
  sector_confirm_a: assert property (@(posedge sys_clk) disable iff (rst)
    (bc_start && op == pfh_pkg::OP_SECTOR_ERASE && step == 3'h5 && state == PFH_WAIT)
    |-> (bc_wdata == pfh_pkg::CODE_SECTOR && bc_addr == op_addr))
    else $error("sector confirm cycle wrong");
  no_cmd_busy_a: assert property (@(posedge sys_clk) disable iff (rst)
    (op == pfh_pkg::OP_CHIP_ERASE && (state == PFH_POLL || state == PFH_POLLW))
    |-> wr_strobe_n)
    else $error("write strobe pulsed during chip erase");
  start_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
    bc_start |-> !bc_busy)
    else $error("bus cycle started while one is running");
  reset_release_a: assert property (@(posedge sys_clk)
    $fell(rst) |-> ##1 flash_reset_n)
    else $error("device reset not released");
endmodule

// ### rtl/pfh_pkg.sv
// Package of constants for the parallel flash host controller
package pfh_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam logic [17:0] ADDR_UNLOCK1 = 18'h00555;
  localparam logic [17:0] ADDR_UNLOCK2 = 18'h00AAA;
  localparam logic [7:0] DATA_UNLOCK1 = 8'hAA;
  localparam logic [7:0] DATA_UNLOCK2 = 8'h55;
  localparam logic [7:0] DATA_SETUP = 8'h80;
  localparam logic [7:0] CODE_CHIP = 8'h10;
  localparam logic [7:0] CODE_SECTOR = 8'h30;
  localparam logic [7:0] CODE_LOCK = 8'h40;
  localparam logic [7:0] CODE_PROGRAM = 8'hA0;
  localparam int TOGGLE_BIT = 6;
  localparam int POLL_BIT = 7;
  localparam int CLK_PERIOD_NS = 25;
  // Bus phase widths, generous against a 70 ns access device
  localparam int SETUP_NS = 30;
  localparam int STROBE_NS = 60;
  localparam int READ_NS = 80;
  localparam int HOLD_NS = 30;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest wait for completion before flagging timeout
  localparam int CHIP_ERASE_TIME_S = 4;
  localparam longint ERASE_CYC = longint'(CHIP_ERASE_TIME_S) * 64'd1000000000
    / CLK_PERIOD_NS;
  // Command codes of the user port
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_PROGRAM = 3'h1;
  localparam logic [2:0] OP_CHIP_ERASE = 3'h2;
  localparam logic [2:0] OP_SECTOR_ERASE = 3'h3;
  localparam logic [2:0] OP_LOCK = 3'h4;
  typedef enum logic [1:0] {PFH_PH_SETUP, PFH_PH_STROBE, PFH_PH_HOLD, PFH_PH_DONE} pfh_phase_t;
endpackage

// ### rtl/pfh_bus_cycle.sv
// One timed bus cycle (read or write) on the flash pins
`timescale 1ns/1ps
module pfh_bus_cycle (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic start, // Begin a cycle, one pulse
  input wire logic is_write, // Cycle is a write
  input wire logic [17:0] addr, // Address of the cycle
  input wire logic [7:0] wdata, // Write data
  input wire logic [7:0] pin_data_in, // Synchronised data lines
  output logic busy, // Cycle in progress
  output logic done, // Cycle end, one pulse
  output logic [7:0] rdata, // Byte read
  output logic [17:0] address_lines, // Address pins
  output logic [7:0] data_out, // Data lines driven value
  output logic data_oe, // Data line drive enable
  output logic chip_sel_n, // Chip select pin
  output logic out_en_n, // Output enable pin
  output logic wr_strobe_n // Write strobe pin
);
  pfh_pkg::pfh_phase_t phase;
  logic wr;
  logic [7:0] cnt;

  always_ff @(posedge sys_clk) begin
    done <= 1'b0;
    if (rst) begin
      busy <= 1'b0;
      phase <= pfh_pkg::PFH_PH_SETUP;
      cnt <= 8'h00;
      wr <= 1'b0;
      address_lines <= 18'h00000;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      chip_sel_n <= 1'b1;
      out_en_n <= 1'b1;
      wr_strobe_n <= 1'b1;
      rdata <= 8'h00;
    end else if (!busy) begin
      if (start) begin
        busy <= 1'b1;
        wr <= is_write;
        phase <= pfh_pkg::PFH_PH_SETUP;
        cnt <= 8'(pfh_pkg::SETUP_CYC);
        address_lines <= addr;
        data_out <= wdata;
        data_oe <= is_write;
        chip_sel_n <= 1'b0;
      end
    end else if (cnt > 8'h01) begin
      cnt <= cnt - 8'h01;
    end else begin
      case (phase)
        pfh_pkg::PFH_PH_SETUP: begin
          // Output enable stays high on writes so the device never drives back
          wr_strobe_n <= !wr;
          out_en_n <= wr;
          phase <= pfh_pkg::PFH_PH_STROBE;
          cnt <= 8'(wr ? pfh_pkg::STROBE_CYC : pfh_pkg::READ_CYC);
        end
        pfh_pkg::PFH_PH_STROBE: begin
          if (!wr) begin
            rdata <= pin_data_in;
          end
          // Strobe rises before chip select so data latches on this edge
          wr_strobe_n <= 1'b1;
          out_en_n <= 1'b1;
          phase <= pfh_pkg::PFH_PH_HOLD;
          cnt <= 8'(pfh_pkg::HOLD_CYC);
        end
        pfh_pkg::PFH_PH_HOLD: begin
          chip_sel_n <= 1'b1;
          data_oe <= 1'b0;
          busy <= 1'b0;
          done <= 1'b1;
          phase <= pfh_pkg::PFH_PH_SETUP;
        end
        default: begin
          phase <= pfh_pkg::PFH_PH_SETUP;
        end
      endcase
    end
  end

  write_oe_high_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!wr_strobe_n) |-> (out_en_n && !chip_sel_n && data_oe))
    else $error("write strobe low without chip select or with output enable");
  no_oe_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!out_en_n) |-> !data_oe)
    else $error("host drives data while output enable low");
endmodule

// ### testbench/pfh_flash_model.sv
// Behavioural parallel flash device facing the host controller
`timescale 1ns/1ps
module pfh_flash_model #(
  parameter int PROG_NS = 400, // Byte program time
  parameter int ERASE_NS = 6000 // Erase time, shortened for simulation
) (
  input wire logic [17:0] address_lines, // Address pins
  input wire logic [7:0] data_in, // Host data value
  input wire logic chip_sel_n, // Chip select
  input wire logic out_en_n, // Output enable
  input wire logic wr_strobe_n, // Write strobe
  input wire logic reset_n, // Device reset
  output logic [7:0] data_out, // Inverse of last byte while floated
  output logic data_oe // High while the device drives
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] mem [int];
  logic [17:0] lat_addr = 18'h00000;
  logic [17:0] last_addr = 18'h00000;
  logic [7:0] last_byte = 8'h00;
  logic [7:0] last_drv = 8'h00;
  logic [2:0] step = 3'h0;
  logic prog_seq = 1'b0;
  logic prog_busy = 1'b0;
  logic locked = 1'b0;
  logic toggle = 1'b0;
  logic busy = 1'b0;
  realtime busy_until = 0;
  wire wr_act = !chip_sel_n && !wr_strobe_n && out_en_n && reset_n;
  wire rd_act = !chip_sel_n && !out_en_n && wr_strobe_n && reset_n;

  function automatic logic [7:0] rd_mem(input logic [17:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  task automatic wipe(input int lo, input int hi);
    for (int a = lo; a <= hi; a++) begin
      if (mem.exists(a)) mem.delete(a);
    end
    busy_until = $realtime + ERASE_NS;
    busy = 1'b1;
  endtask

  // Override by an elevated reset level is analog and not modelled
  task automatic take_write(input logic [17:0] a, input logic [7:0] d);
    logic [11:0] ea;
    logic [7:0] ed;
    int sz;
    ea = (step == 3'h1 || step == 3'h4) ? 12'hAAA : 12'h555;
    ed = (step == 3'h1 || step == 3'h4) ? 8'h55 : (step == 3'h2 ? 8'h80 : 8'hAA);
    if (busy) return;
    if (prog_seq) begin
      if (!(locked && a < 18'h04000)) mem[a] = rd_mem(a) & d;
      last_addr = a;
      last_byte = d;
      prog_busy = 1'b1;
      prog_seq = 1'b0;
      busy_until = $realtime + PROG_NS;
      busy = 1'b1;
    end else if (step == 3'h2 && a[11:0] == 12'h555 && d == pfh_pkg::CODE_PROGRAM) begin
      prog_seq = 1'b1;
      step = 3'h0;
    end else if (step == 3'h5) begin
      step = 3'h0;
      if (d == pfh_pkg::CODE_SECTOR) begin
        sz = a < 18'h04000 ? 'h4000 : a < 18'h08000 ? 'h2000 : a < 18'h10000 ? 'h8000 : 'h10000;
        if (!(locked && a < 18'h04000)) wipe(int'(a) & ~(sz - 1), (int'(a) | (sz - 1)));
      end else if (a[11:0] == ea && d == pfh_pkg::CODE_CHIP) begin
        wipe(locked ? 'h4000 : 0, 'h3FFFF);
      end else if (a[11:0] == ea && d == pfh_pkg::CODE_LOCK) begin
        locked = 1'b1;
      end
    end else begin
      step = (a[11:0] == ea && d == ed) ? step + 3'h1 : 3'h0;
    end
  endtask

  // ----------------------------------------
  // Bus behaviour
  // ----------------------------------------
  always @(posedge wr_act) lat_addr = address_lines;
  always @(negedge wr_act) begin
    if (reset_n) take_write(lat_addr, data_in);
  end
  always #5 begin
    if (busy && $realtime >= busy_until) begin
      busy = 1'b0;
      prog_busy = 1'b0;
    end
  end
  always @(negedge reset_n) begin
    busy_until = 0;
    busy = 1'b0;
    prog_busy = 1'b0;
    prog_seq = 1'b0;
    step = 3'h0;
  end
  always @(negedge rd_act) begin
    if (busy) toggle = ~toggle;
  end
  always @(rd_act, address_lines, busy, toggle) begin
    data_oe = rd_act;
    if (rd_act) begin
      data_out = rd_mem(address_lines);
      if (busy) data_out[6] = toggle;
      if (prog_busy && address_lines == last_addr) data_out[7] = ~last_byte[7];
      last_drv = data_out;
    end else begin
      data_out = ~last_drv;
    end
  end
endmodule

// ### testbench/parallel_flash_command_erase_control_bench.sv
// Self-checking bench of the parallel flash host controller
`timescale 1ns/1ps
module parallel_flash_command_erase_control_bench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [17:0] cmd_addr = 18'h00000;
  logic [7:0] cmd_wdata = 8'h00;
  logic [7:0] data_lines_in;
  logic [7:0] rsp_rdata, data_lines_out, dev_data;
  logic [17:0] address_lines;
  logic cmd_ready, rsp_valid, rsp_timeout, data_lines_oe, dev_oe;
  logic chip_sel_n, out_en_n, wr_strobe_n, flash_reset_n;
  int error_cnt = 0;
  int samples_checked = 0;

  always #12.5 sys_clk = ~sys_clk;
  assign data_lines_in = data_lines_oe ? data_lines_out : dev_data;

  pfh_host #(.ERASE_TIMEOUT(2000)) u_dut (.sys_clk, .rst, .cmd_valid, .cmd_op, .cmd_addr,
    .cmd_wdata, .data_lines_in, .cmd_ready, .rsp_valid, .rsp_rdata, .rsp_timeout,
    .address_lines, .data_lines_out, .data_lines_oe, .chip_sel_n, .out_en_n,
    .wr_strobe_n, .flash_reset_n);
  pfh_flash_model u_flash (.address_lines, .data_in(data_lines_out), .chip_sel_n,
    .out_en_n, .wr_strobe_n, .reset_n(flash_reset_n), .data_out(dev_data), .data_oe(dev_oe));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wait_sig(ref logic s);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (s !== 1'b1 && n < 6000);
    if (s !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: handshake never came", $time);
      close_out();
    end
  endtask

  task automatic issue(input logic [2:0] op, input logic [17:0] a, input logic [7:0] d);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    wait_sig(cmd_ready);
    cmd_valid <= 1'b0;
  endtask

  task automatic run_op(input logic [2:0] op, input logic [17:0] a, input logic [7:0] d);
    issue(op, a, d);
    wait_sig(rsp_valid);
    chk({7'h00, rsp_timeout}, 8'h00, "completion timed out");
  endtask

  task automatic rd(input logic [17:0] a, input logic [7:0] e, input string m);
    run_op(pfh_pkg::OP_READ, a, 8'h00);
    chk(rsp_rdata, e, m);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_program();
    rd(18'h10020, 8'hFF, "erased byte");
    run_op(pfh_pkg::OP_PROGRAM, 18'h10020, 8'h5A);
    rd(18'h10020, 8'h5A, "programmed byte");
    run_op(pfh_pkg::OP_PROGRAM, 18'h10020, 8'h70);
    rd(18'h10020, 8'h50, "program only clears bits");
    rd(18'h00555, 8'hFF, "command address kept");
    rd(18'h00AAA, 8'hFF, "command address kept");
    $display("program test done");
  endtask

  // Erase the sector just below a boundary; the one above must survive
  task automatic sec_pair(input logic [17:0] a);
    run_op(pfh_pkg::OP_PROGRAM, a - 18'h00001, 8'h3C);
    run_op(pfh_pkg::OP_PROGRAM, a, 8'h3C);
    run_op(pfh_pkg::OP_SECTOR_ERASE, a - 18'h00001, 8'h00);
    rd(a - 18'h00001, 8'hFF, "sector erased");
    rd(a, 8'h3C, "neighbour sector kept");
  endtask

  task automatic t_sectors();
    sec_pair(18'h06000);
    sec_pair(18'h10000);
    sec_pair(18'h20000);
    $display("sector test done");
  endtask

  task automatic t_lock();
    run_op(pfh_pkg::OP_PROGRAM, 18'h00100, 8'h33);
    run_op(pfh_pkg::OP_LOCK, 18'h00000, 8'h00);
    // A refused program never shows the written top bit, so polling runs out
    issue(pfh_pkg::OP_PROGRAM, 18'h00200, 8'h00);
    wait_sig(rsp_valid);
    chk({7'h00, rsp_timeout}, 8'h01, "refused program times out");
    rd(18'h00200, 8'hFF, "locked boot refuses program");
    run_op(pfh_pkg::OP_SECTOR_ERASE, 18'h00000, 8'h00);
    rd(18'h00100, 8'h33, "locked boot refuses erase");
    run_op(pfh_pkg::OP_CHIP_ERASE, 18'h00000, 8'h00);
    rd(18'h00100, 8'h33, "boot spared by chip erase");
    rd(18'h20000, 8'hFF, "main block wiped");
    $display("lockout test done");
  endtask

  task automatic t_reset();
    run_op(pfh_pkg::OP_PROGRAM, 18'h30000, 8'hA5);
    issue(pfh_pkg::OP_CHIP_ERASE, 18'h00000, 8'h00);
    repeat (60) @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk({flash_reset_n, chip_sel_n, data_lines_oe, dev_oe, 4'h0}, 8'h40, "pins in reset");
    rst <= 1'b0;
    rd(18'h00100, 8'h33, "read after reset");
    run_op(pfh_pkg::OP_CHIP_ERASE, 18'h00000, 8'h00);
    rd(18'h30000, 8'hFF, "reissued erase done");
    $display("reset test done");
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_program();
    t_sectors();
    t_lock();
    t_reset();
    close_out();
  end
endmodule
